/* File: logic/module_reset_distribution.sv */
// reset distribution, boot lockdown and configuration status of the processor module
`timescale 1ns/100ps
`default_nettype none
`include "module_reset_consts.svh"
module module_reset_distribution
	import module_reset_pkg::*;
#(
	parameter int unsigned MIN_PULSE_CYCLES = `MIN_PULSE_CYCLES,
	parameter int unsigned FILTER_CNT_W = `FILTER_CNT_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// apb slave
	input wire apb_req_t i_apb,
	output apb_rsp_t o_apb,
	// reset pins
	input wire logic i_master_power_on_reset_n,
	input wire logic i_system_reset_n,
	input wire logic i_module_reset_in_n,
	input wire logic [`EXPANDER_W-1:0] i_expander_port,
	// configuration pins
	input wire logic i_config_program_request_n,
	input wire logic i_config_init_n,
	// processor status, same clock
	input wire logic i_boot_rom_done,
	input wire logic i_config_complete,
	input wire logic i_config_failed,
	// carrier reset, open drain
	output logic o_carrier_reset_out_n,
	output logic o_carrier_reset_out_n_oe,
	// resets to the processor
	output logic o_system_reset_n,
	output logic o_debug_reset_n,
	// boot and configuration status
	output logic o_boot_enable,
	output logic o_lockdown,
	output logic o_config_done,
	output logic o_config_error_status,
	output logic o_config_error_out,
	// interrupt
	output logic o_irq
);

	localparam int unsigned NPIN = 4;
	localparam int unsigned PIN_SYS = 0;
	localparam int unsigned PIN_MOD = 1;
	localparam int unsigned PIN_SOFT = 2;
	localparam int unsigned PIN_PROG = 3;

	// ==================================================
	// power-on reset synchroniser
	logic por_async_n;
	logic por_sync1_reg;
	logic por_rst_n;

	assign por_async_n = i_rst_n & i_master_power_on_reset_n;

	// chip-wide reset
	// asserts at once, releases on the clock
	always_ff @(posedge i_clk or negedge por_async_n) begin
		if (!por_async_n) begin
			por_sync1_reg <= 1'b0;
			por_rst_n <= 1'b0;
		end else begin
			por_sync1_reg <= 1'b1;
			por_rst_n <= por_sync1_reg;
		end
	end

	// ==================================================
	// pin synchronisers and filters
	logic [NPIN-1:0] pin_n;
	logic [NPIN-1:0] pin_active;
	logic init_sync1_reg;
	logic init_sync2_reg;

	assign pin_n[PIN_SYS] = i_system_reset_n;
	assign pin_n[PIN_MOD] = i_module_reset_in_n;
	assign pin_n[PIN_SOFT] = i_expander_port[`EXPANDER_SOFT_RESET_BIT];
	assign pin_n[PIN_PROG] = i_config_program_request_n;

	for (genvar g = 0; g < NPIN; g++) begin : g_pin
		low_pulse_filter #(
			.MIN_CYCLES((g == PIN_SYS || g == PIN_MOD) ? MIN_PULSE_CYCLES : 1),
			.CNT_W(FILTER_CNT_W)
		) u_filter (
			.i_clk(i_clk),
			.i_rst_n(por_rst_n),
			.i_pin_n(pin_n[g]),
			.o_active(pin_active[g])
		);
	end

	// init pin is only reported, it never holds boot
	always_ff @(posedge i_clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			init_sync1_reg <= 1'b1;
			init_sync2_reg <= 1'b1;
		end else begin
			init_sync1_reg <= i_config_init_n;
			init_sync2_reg <= init_sync1_reg;
		end
	end

	// ==================================================
	// register state
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [31:0] mask_reg;
	logic [31:0] mask_next;
	irq_evt_t irq_reg;
	irq_evt_t irq_next;
	irq_evt_t evt;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [31:0] status_word;
	logic setup_phase;
	logic access_phase;
	logic addr_mapped;

	// ==================================================
	// system reset and carrier reset
	logic sys_active;
	logic sysrst_reg;
	logic sysrst_next;
	logic carrier_oe_reg;
	logic carrier_oe_next;

	assign sys_active = pin_active[PIN_SYS] | pin_active[PIN_MOD] | ctrl_reg[`CTRL_SW_SYSRST_BIT];

	always_comb begin
		sysrst_next = sys_active;
		carrier_oe_next = pin_active[PIN_SOFT];
	end

	always_ff @(posedge i_clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			sysrst_reg <= 1'b0;
			carrier_oe_reg <= 1'b0;
		end else begin
			sysrst_reg <= sysrst_next;
			carrier_oe_reg <= carrier_oe_next;
		end
	end

	assign o_carrier_reset_out_n = 1'b0;
	assign o_carrier_reset_out_n_oe = ~por_rst_n | carrier_oe_reg;

	assign o_system_reset_n = ~sysrst_reg;
	assign o_debug_reset_n = por_rst_n;

	// ==================================================
	// boot sequence
	boot_state_t state_reg;
	boot_state_t state_next;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			BOOT_ROM: begin
				if (sys_active) begin
					state_next = BOOT_LOCKDOWN;
				end else if (i_boot_rom_done) begin
					state_next = BOOT_RUN;
				end
			end
			BOOT_RUN: begin
				state_next = BOOT_RUN;
			end
			BOOT_LOCKDOWN: begin
				state_next = BOOT_LOCKDOWN;
			end
			default: begin
				state_next = BOOT_LOCKDOWN;
			end
		endcase
	end

	// a system reset during the boot ROM moves to lockdown, held until power-on reset
	always_ff @(posedge i_clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			state_reg <= BOOT_ROM;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_boot_enable = por_rst_n & (state_reg != BOOT_LOCKDOWN);
	assign o_lockdown = (state_reg == BOOT_LOCKDOWN);

	// ==================================================
	// configuration status
	logic done_reg;
	logic done_next;
	logic error_reg;
	logic error_next;

	always_comb begin
		done_next = done_reg;
		error_next = error_reg;
		if (pin_active[PIN_PROG]) begin
			done_next = 1'b0;
			error_next = 1'b0;
		end else if (i_config_failed) begin
			error_next = 1'b1;
			done_next = 1'b0;
		end else if (i_config_complete && !error_reg) begin
			done_next = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			done_reg <= 1'b0;
			error_reg <= 1'b0;
		end else begin
			done_reg <= done_next;
			error_reg <= error_next;
		end
	end

	assign o_config_done = done_reg;
	assign o_config_error_status = error_reg;
	assign o_config_error_out = error_reg;

	// ==================================================
	// interrupt events
	always_comb begin
		evt.system_reset = sysrst_next & ~sysrst_reg;
		evt.lockdown = (state_next == BOOT_LOCKDOWN) && (state_reg != BOOT_LOCKDOWN);
		evt.config_done = done_next & ~done_reg;
		evt.config_error = error_next & ~error_reg;
		evt.carrier_reset = carrier_oe_next & ~carrier_oe_reg;
	end

	// ==================================================
	// apb slave
	assign setup_phase = i_apb.psel & ~i_apb.penable;
	assign access_phase = i_apb.psel & i_apb.penable;
	assign addr_mapped = (i_apb.paddr == `ADDR_CTRL) || (i_apb.paddr == `ADDR_STATUS) ||
		(i_apb.paddr == `ADDR_IRQ_STATUS) || (i_apb.paddr == `ADDR_IRQ_MASK);

	always_comb begin
		status_word = `DATA_ZERO;
		status_word[`ST_LOCKDOWN_BIT] = o_lockdown;
		status_word[`ST_RUNNING_BIT] = (state_reg == BOOT_RUN);
		status_word[`ST_CFG_DONE_BIT] = done_reg;
		status_word[`ST_CFG_ERROR_BIT] = error_reg;
		status_word[`ST_SYSRST_BIT] = sysrst_reg;
		status_word[`ST_CARRIER_RST_BIT] = carrier_oe_reg;
		status_word[`ST_CFG_INIT_N_BIT] = init_sync2_reg;
		status_word[`ST_PROG_REQ_BIT] = pin_active[PIN_PROG];
	end

	always_comb begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		rdata_next = rdata_reg;
		irq_next = irq_reg;
		// read data is captured in the setup cycle
		if (setup_phase) begin
			case (i_apb.paddr)
				`ADDR_CTRL: rdata_next = ctrl_reg;
				`ADDR_STATUS: rdata_next = status_word;
				`ADDR_IRQ_STATUS: rdata_next = {{(32-`EVT_W){1'b0}}, irq_reg};
				`ADDR_IRQ_MASK: rdata_next = mask_reg;
				default: rdata_next = `DATA_ZERO;
			endcase
		end
		if (access_phase && i_apb.pwrite) begin
			case (i_apb.paddr)
				`ADDR_CTRL: ctrl_next = {31'h0000_0000, i_apb.pwdata[`CTRL_SW_SYSRST_BIT]};
				`ADDR_IRQ_MASK: mask_next = {{(32-`EVT_W){1'b0}}, i_apb.pwdata[`EVT_W-1:0]};
				default: begin
				end
			endcase
		end
		// read clears only what was reported, a new event wins
		if (access_phase && !i_apb.pwrite && (i_apb.paddr == `ADDR_IRQ_STATUS)) begin
			irq_next = irq_reg & ~irq_evt_t'(rdata_reg[`EVT_W-1:0]);
		end
		irq_next = irq_next | evt;
	end

	always_ff @(posedge i_clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			ctrl_reg <= `CTRL_RESET;
			mask_reg <= `IRQ_MASK_RESET;
			rdata_reg <= `DATA_ZERO;
			irq_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
		end
	end

	always_comb begin
		o_apb.prdata = rdata_reg;
		o_apb.pready = 1'b1;
		o_apb.pslverr = access_phase & ~addr_mapped;
	end

	assign o_irq = |(irq_reg & mask_reg[`EVT_W-1:0]);

endmodule : module_reset_distribution

`default_nettype wire

/* File: logic/module_reset_consts.svh */
// constants for the module reset and boot-status sequencer
`ifndef MODULE_RESET_CONSTS_SVH
`define MODULE_RESET_CONSTS_SVH

// ==================================================
// clock and timing
`define CLK_FREQ_MHZ 10
`define MIN_PULSE_REF_PERIODS 3
`define MIN_PULSE_NS 90
`define MIN_PULSE_CYCLES_RAW (((`MIN_PULSE_NS * `CLK_FREQ_MHZ) + 999) / 1000)
`define MIN_PULSE_CYCLES ((`MIN_PULSE_CYCLES_RAW < 1) ? 1 : `MIN_PULSE_CYCLES_RAW)
`define FILTER_CNT_W 4

// ==================================================
// expander wiring
`define EXPANDER_W 8
`define EXPANDER_SOFT_RESET_BIT 7

// ==================================================
// apb register map
`define APB_ADDR_W 8
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h0C

// ==================================================
// field positions
`define CTRL_SW_SYSRST_BIT 0
`define ST_LOCKDOWN_BIT 0
`define ST_RUNNING_BIT 1
`define ST_CFG_DONE_BIT 2
`define ST_CFG_ERROR_BIT 3
`define ST_SYSRST_BIT 4
`define ST_CARRIER_RST_BIT 5
`define ST_CFG_INIT_N_BIT 6
`define ST_PROG_REQ_BIT 7
`define EVT_W 5

// ==================================================
// reset values
`define CTRL_RESET 32'h0000_0000
`define IRQ_MASK_RESET 32'h0000_0000
`define DATA_ZERO 32'h0000_0000

`endif

/* File: logic/module_reset_pkg.sv */
// types shared by the module reset sequencer
`include "module_reset_consts.svh"

package module_reset_pkg;

	// ==================================================
	// boot sequence states
	typedef enum logic [1:0] {
		BOOT_ROM,
		BOOT_RUN,
		BOOT_LOCKDOWN
	} boot_state_t;

	// ==================================================
	// interrupt events, one sticky bit each
	typedef struct packed {
		logic carrier_reset;
		logic config_error;
		logic config_done;
		logic lockdown;
		logic system_reset;
	} irq_evt_t;

	// ==================================================
	// apb request and response
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`APB_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

endpackage : module_reset_pkg

/* File: logic/low_pulse_filter.sv */
// two-flop synchroniser with a minimum-width filter for an active-low pin
`timescale 1ns/100ps
`default_nettype none

module low_pulse_filter #(
	parameter int unsigned MIN_CYCLES = 1,
	parameter int unsigned CNT_W = 4
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// pin
	input wire logic i_pin_n,
	// filtered level, high while the pin is accepted as low
	output logic o_active
);

	logic sync1_reg;
	logic sync2_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic active_reg;
	logic active_next;

	// ==================================================
	// synchroniser, idle high
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= i_pin_n;
			sync2_reg <= sync1_reg;
		end
	end

	// ==================================================
	// width counter
	always_comb begin
		cnt_next = cnt_reg;
		active_next = active_reg;
		if (sync2_reg) begin
			cnt_next = '0;
			active_next = 1'b0;
		end else if (cnt_reg < CNT_W'(MIN_CYCLES)) begin
			cnt_next = cnt_reg + CNT_W'(1);
			if ((cnt_reg + CNT_W'(1)) >= CNT_W'(MIN_CYCLES)) begin
				active_next = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= '0;
			active_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			active_reg <= active_next;
		end
	end

	assign o_active = active_reg;

endmodule : low_pulse_filter

`default_nettype wire

/* File: testbench/carrier_card_model.sv */
// behavioural carrier card: reset request driver and open-drain pull-up
`timescale 1ns/100ps
`default_nettype none
module carrier_card_model #(
	parameter int MIN_CYC = 3
) (
	// clock
	input wire logic i_clk,
	// request from the bench
	input wire logic i_req,
	// open-drain pin from the module
	input wire logic i_od_n,
	input wire logic i_od_oe,
	// to the module and the bench
	output logic o_module_reset_in_n,
	output logic o_line
);
	int cnt = 0;
	always @(posedge i_clk) begin
		if (i_req)
			cnt <= MIN_CYC;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	assign o_module_reset_in_n = !(i_req || cnt > 0);
	// rail settling before boot is the carrier's own duty, not modelled
	assign o_line = i_od_oe ? i_od_n : 1'b1;
endmodule : carrier_card_model
`default_nettype wire

/* File: testbench/module_reset_checker.sv */
// concurrent checks on the module reset sequencer ports
`timescale 1ns/100ps
`default_nettype none
`include "module_reset_consts.svh"
module module_reset_checker (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// watched inputs
	input wire logic i_master_power_on_reset_n,
	input wire logic i_module_reset_in_n,
	input wire logic [`EXPANDER_W-1:0] i_expander_port,
	input wire logic i_config_program_request_n,
	input wire logic i_config_complete,
	input wire logic i_config_failed,
	// watched outputs
	input wire logic o_carrier_reset_out_n,
	input wire logic o_carrier_reset_out_n_oe,
	input wire logic o_system_reset_n,
	input wire logic o_debug_reset_n,
	input wire logic o_boot_enable,
	input wire logic o_lockdown,
	input wire logic o_config_done,
	input wire logic o_config_error_status,
	input wire logic o_config_error_out
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n || !i_master_power_on_reset_n);
	// ==================================================
	// sequences
	// four samples cover two sync flops, the filter and the output register
	sequence soft_low_s; !i_expander_port[`EXPANDER_SOFT_RESET_BIT] [*4]; endsequence
	sequence soft_high_s; i_expander_port[`EXPANDER_SOFT_RESET_BIT] [*4]; endsequence
	sequence carrier_req_s; (!i_module_reset_in_n && !o_lockdown) [*4]; endsequence
	sequence prog_idle_s; i_config_program_request_n [*4]; endsequence
	// ==================================================
	// assertions
	por_hold_a: assert property (disable iff (!i_rst_n) !i_master_power_on_reset_n |->
		o_carrier_reset_out_n_oe && !o_debug_reset_n && !o_boot_enable) else $error("por hold");
	od_data_a: assert property (!o_carrier_reset_out_n) else $error("open drain data");
	soft_assert_a: assert property (soft_low_s |=> o_carrier_reset_out_n_oe) else $error("soft");
	soft_release_a: assert property (soft_high_s |=> !o_carrier_reset_out_n_oe) else $error("rel");
	carrier_sys_a: assert property (carrier_req_s |=> !o_system_reset_n) else $error("sysrst");
	debug_keep_a: assert property (!o_system_reset_n |-> o_debug_reset_n) else $error("debug");
	lock_hold_a: assert property (o_lockdown |=> o_lockdown) else $error("lock left");
	lock_boot_a: assert property (o_lockdown |-> !o_boot_enable) else $error("lock boot");
	cfg_done_a: assert property (prog_idle_s ##0 (i_config_complete && !i_config_failed
		&& !o_config_error_status) |=> o_config_done) else $error("done");
	cfg_error_a: assert property (prog_idle_s ##0 i_config_failed |=> o_config_error_status)
		else $error("error");
	err_pair_a: assert property (o_config_error_status == o_config_error_out) else $error("pair");
endmodule : module_reset_checker

bind module_reset_distribution module_reset_checker u_module_reset_checker (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_master_power_on_reset_n(i_master_power_on_reset_n),
	.i_module_reset_in_n(i_module_reset_in_n), .i_expander_port(i_expander_port),
	.i_config_program_request_n(i_config_program_request_n), .i_config_complete(i_config_complete),
	.i_config_failed(i_config_failed), .o_carrier_reset_out_n(o_carrier_reset_out_n),
	.o_carrier_reset_out_n_oe(o_carrier_reset_out_n_oe), .o_system_reset_n(o_system_reset_n),
	.o_debug_reset_n(o_debug_reset_n), .o_boot_enable(o_boot_enable), .o_lockdown(o_lockdown),
	.o_config_done(o_config_done), .o_config_error_status(o_config_error_status),
	.o_config_error_out(o_config_error_out));
`default_nettype wire

/* File: testbench/module_reset_distribution_tb.sv */
// self-checking bench for the module reset sequencer
`timescale 1ns/100ps
`default_nettype none
`include "module_reset_consts.svh"
module module_reset_distribution_tb;
	import module_reset_pkg::*;
	logic clk, rst_n, por_n, sys_n, mod_n, prog_n, rom, ok, bad, req, line;
	logic co_n, co_oe, sys_o, dbg, boot, lock, done, est, eout, irq, e;
	logic [7:0] port;
	logic [7:0] seed = 8'h10;
	logic [31:0] q;
	apb_req_t apb;
	apb_rsp_t rsp;
	int fails = 0;
	int checked = 0;
	int exp_irq = 0;
	module_reset_distribution u_module_reset_distribution (.i_clk(clk), .i_rst_n(rst_n), .i_apb(apb),
		.o_apb(rsp), .i_master_power_on_reset_n(por_n), .i_system_reset_n(sys_n), .i_module_reset_in_n(mod_n),
		.i_expander_port(port), .i_config_program_request_n(prog_n), .i_config_init_n(1'b1),
		.i_boot_rom_done(rom), .i_config_complete(ok), .i_config_failed(bad), .o_carrier_reset_out_n(co_n),
		.o_carrier_reset_out_n_oe(co_oe), .o_system_reset_n(sys_o), .o_debug_reset_n(dbg),
		.o_boot_enable(boot), .o_lockdown(lock), .o_config_done(done), .o_config_error_status(est),
		.o_config_error_out(eout), .o_irq(irq));
	carrier_card_model u_carrier_card_model (.i_clk(clk), .i_req(req), .i_od_n(co_n), .i_od_oe(co_oe),
		.o_module_reset_in_n(mod_n), .o_line(line));
	// ==================================================
	// helpers
	task cyc(input int n); repeat (n) @(posedge clk); endtask : cyc
	task chk_bit(input string n, input logic x, input logic g);
		checked++;
		if (g !== x) begin
			fails++;
			$display("ERROR %s expected %b seen %b", n, x, g);
		end
	endtask : chk_bit
	task chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask : chk_word
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		apb.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		e = rsp.pslverr;
		apb <= '0;
		@(posedge clk);
	endtask : bus
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task print_verdict;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	// ==================================================
	// clock and watchdog
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	initial begin
		cyc(3000);
		fails++;
		print_verdict;
	end
	// ==================================================
	// tests
	initial begin
		// chip reset low, every other pin at its idle level
		{rst_n, por_n, sys_n, prog_n, rom, ok, bad, req} = 8'h70;
		port = 8'hFF;
		apb = '0;
		cyc(8);
		rst_n <= 1'b1;
		cyc(4);
		bus(0, `ADDR_CTRL, 0); chk_word("ctrl", `CTRL_RESET, q);
		bus(0, `ADDR_IRQ_MASK, 0); chk_word("mask", `IRQ_MASK_RESET, q);
		bus(0, 8'h10, 0); chk_bit("slverr", 1'b1, e);
		$display("test registers done");
		sys_n <= 1'b0; cyc(6);
		chk_bit("lock", 1'b1, lock);
		chk_bit("boot", 1'b0, boot);
		chk_bit("masked irq", 1'b0, irq);
		sys_n <= 1'b1; rom <= 1'b1; cyc(6); rom <= 1'b0; cyc(1);
		chk_bit("lock held", 1'b1, lock);
		bus(0, `ADDR_IRQ_STATUS, 0); chk_bit("lock event", 1'b1, q[1]);
		por_n <= 1'b0; cyc(2);
		chk_bit("por line", 1'b0, line);
		chk_bit("por boot", 1'b0, boot);
		por_n <= 1'b1; cyc(4);
		chk_bit("lock clear", 1'b0, lock);
		$display("test lockdown done");
		// boot ROM finishes before any system reset
		rom <= 1'b1; cyc(1); rom <= 1'b0; cyc(2);
		bus(0, `ADDR_IRQ_STATUS, 0);
		bus(1, `ADDR_IRQ_MASK, 32'h0000_0001);
		req <= 1'b1; cyc(1); req <= 1'b0; cyc(4);
		exp_irq = exp_irq | 1;
		chk_bit("carrier sysrst", 1'b0, sys_o);
		chk_bit("debug kept", 1'b1, dbg);
		chk_bit("irq", 1'b1, irq);
		cyc(6);
		bus(0, `ADDR_IRQ_STATUS, 0); chk_word("irq status", exp_irq, q & 32'h0000_0001);
		chk_bit("irq clear", 1'b0, irq);
		bus(1, `ADDR_CTRL, 32'h0000_0001); cyc(2);
		chk_bit("sw sysrst", 1'b0, sys_o);
		bus(1, `ADDR_CTRL, 0);
		$display("test system reset done");
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			port <= {1'b0, seed[6:0]}; cyc(6);
			chk_bit("soft low", 1'b0, line);
			port <= {1'b1, seed[6:0]}; cyc(6);
			chk_bit("soft rel", 1'b1, line);
		end
		$display("test soft reset done");
		bad <= 1'b1; cyc(1); bad <= 1'b0; cyc(2);
		chk_bit("err status", 1'b1, est);
		chk_bit("err out", 1'b1, eout);
		ok <= 1'b1; cyc(1); ok <= 1'b0; cyc(2);
		chk_bit("done blocked", 1'b0, done);
		prog_n <= 1'b0; cyc(5); prog_n <= 1'b1; cyc(5);
		chk_bit("err clear", 1'b0, est);
		ok <= 1'b1; cyc(1); ok <= 1'b0; cyc(2);
		chk_bit("done", 1'b1, done);
		bus(0, `ADDR_STATUS, 0);
		chk_word("status", (32'h0000_0001 << `ST_RUNNING_BIT) | (32'h0000_0001 << `ST_CFG_DONE_BIT) |
			(32'h0000_0001 << `ST_CFG_INIT_N_BIT), q);
		$display("test configuration done");
		print_verdict;
	end
endmodule : module_reset_distribution_tb
`default_nettype wire
